// >>> hw/tbu_trace_unit.sv
// Trace and breakpoint unit: breakpoint registers, trace event
// gathering, trace fault delivery and trace enable flag upkeep.
// Assumes all inputs come from the pipeline on core_clk_in.
//
// How it works
// RULE_01 - Data breakpoint: reads, writes, or both
// RULE_02 - Every data access kind is checked
// RULE_03 - Control space fault always reported first
// RULE_04 - Instruction breakpoint: word address, two mode bits
// RULE_05 - Instruction break fires only armed and enabled
// RULE_06 - Software avoids mixed mode pairs while tracing
// RULE_07 - Breakpoints accessible by control op, word access
// RULE_08 - Direct store may match old or new
// RULE_09 - Software prefers control op for updates
// RULE_10 - Enabled trace groups fault; prereturn before execution
// RULE_11 - Fault call traced when call mode on
// RULE_12 - Mark needs breakpoint mode; forced mark always
// RULE_13 - Breakpoint matches raise trace fault
// RULE_14 - Events merged, never empty, prereturn alone
// RULE_15 - Others first, prereturn on handler return
// RULE_16 - Trace handler call clears trace enable
// RULE_17 - Other supervisor calls load table bit
// RULE_18 - Interrupt entry saves state, clears enable
// RULE_19 - Interrupt return restores saved enable
// RULE_20 - Call and return use resulting enable
// RULE_21 - Data mode pairs: write, both, read
// RULE_22 - Data breakpoint needs both enables set
// RULE_23 - Any referenced byte matching address hits
// RULE_24 - Write without rights: unchanged, unimplemented fault
`timescale 1ns/100ps

module tbu_trace_unit
	import tbu_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Register access by control op or word load/store
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic reg_sysctl_in,
	input wire logic reg_word_in,
	input wire logic [`TBU_IDX_W-1:0] reg_idx_in,
	input wire tbu_word_t reg_wdata_in,
	input wire logic rights_req_in,
	input wire logic emu_hold_in,
	// Executing instruction
	input wire logic ex_valid_in,
	input wire tbu_word_t ex_ip_in,
	input wire logic [`TBU_GRP_W-1:0] ex_groups_in,
	input wire logic ex_prereturn_in,
	input wire logic ex_mark_in,
	input wire logic ex_fmark_in,
	input wire logic [`TBU_REC_W-1:0] trace_mode_in,
	// Data access of any origin
	input wire logic dacc_valid_in,
	input wire tbu_word_t dacc_addr_in,
	input wire logic [4:0] dacc_len_in,
	input wire logic dacc_write_in,
	input wire logic dacc_ctl_fault_in,
	// Call and return sequencer
	input wire logic fault_call_in,
	input wire logic sup_call_in,
	input wire logic sup_call_trace_in,
	input wire logic ssp_te_in,
	input wire logic intr_entry_in,
	input wire logic intr_ret_in,
	input wire logic intr_rec_te_in,
	input wire logic trace_ret_in,
	input wire logic trace_enable_flag_wr_in,
	input wire logic trace_enable_flag_val_in,
	// Answers
	output logic trace_fault_out,
	output tbu_rec_t trace_record_out,
	output logic ctl_fault_out,
	output logic unimp_fault_out,
	output logic te_out,
	output logic intr_saved_te_out,
	output tbu_word_t reg_rdata_out,
	output logic [7:0] rights_out
);

	// ************************************************************
	// Breakpoint registers and access rights
	// ************************************************************
	tbu_word_t ib_reg [`TBU_NUM_IB];
	tbu_word_t db_reg [`TBU_NUM_DB];
	logic [7:0] break_control_reg;
	logic rights;
	tbu_word_t next_ib [`TBU_NUM_IB];
	tbu_word_t next_db [`TBU_NUM_DB];
	logic [7:0] next_break_control_reg;
	logic next_rights;
	logic next_unimp;
	tbu_word_t next_rdata;
	logic [7:0] next_rights_val;
	logic acc_ok;

	always_comb begin
		next_ib = ib_reg;
		next_db = db_reg;
		next_break_control_reg = break_control_reg;
		next_rdata = reg_rdata_out;
		next_unimp = 1'b0;
		next_rights = rights;
		// Byte and halfword loads or stores do not reach these registers
		acc_ok = reg_sysctl_in || reg_word_in; // RULE_07
		if (emu_hold_in) begin
			next_rights = 1'b0;
		end else if (rights_req_in) begin
			next_rights = 1'b1;
		end
		next_rights_val = next_rights ? `TBU_RIGHTS_VAL : 8'h00;
		if (reg_wr_in && acc_ok && !rights) begin
			next_unimp = 1'b1; // RULE_24
		end else if (reg_wr_in && acc_ok) begin
			// New value takes effect one cycle later
			case (reg_idx_in) // RULE_08
				`TBU_IDX_IB0: next_ib[0] = reg_wdata_in;
				`TBU_IDX_IB1: next_ib[1] = reg_wdata_in;
				`TBU_IDX_DB0: next_db[0] = reg_wdata_in;
				`TBU_IDX_DB1: next_db[1] = reg_wdata_in;
				`TBU_IDX_BREAK_CONTROL_REG: next_break_control_reg = reg_wdata_in[7:0];
				default: next_unimp = 1'b0;
			endcase
		end
		if (reg_rd_in && acc_ok) begin
			case (reg_idx_in) // RULE_07
				`TBU_IDX_IB0: next_rdata = ib_reg[0];
				`TBU_IDX_IB1: next_rdata = ib_reg[1];
				`TBU_IDX_DB0: next_rdata = db_reg[0];
				`TBU_IDX_DB1: next_rdata = db_reg[1];
				`TBU_IDX_BREAK_CONTROL_REG: next_rdata = {24'h000000, break_control_reg};
				default: next_rdata = `TBU_WORD_RST;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ib_reg <= '{default: `TBU_WORD_RST};
			db_reg <= '{default: `TBU_WORD_RST};
			break_control_reg <= `TBU_BREAK_CONTROL_REG_RST;
			rights <= 1'b0;
			rights_out <= 8'h00;
			unimp_fault_out <= 1'b0;
			reg_rdata_out <= `TBU_WORD_RST;
		end else begin
			ib_reg <= next_ib;
			db_reg <= next_db;
			break_control_reg <= next_break_control_reg;
			rights <= next_rights;
			rights_out <= next_rights_val;
			unimp_fault_out <= next_unimp;
			reg_rdata_out <= next_rdata;
		end
	end

	// ************************************************************
	// Trace enable flag across calls and returns
	// ************************************************************
	logic te;
	logic saved_te;
	logic next_te;
	logic next_saved_te;

	always_comb begin
		next_te = te;
		next_saved_te = saved_te;
		if (sup_call_trace_in) begin
			next_te = 1'b0; // RULE_16
		end else if (intr_entry_in) begin
			next_saved_te = te; // RULE_18
			next_te = 1'b0;
		end else if (intr_ret_in) begin
			next_te = intr_rec_te_in; // RULE_19
		end else if (sup_call_in) begin
			next_te = ssp_te_in; // RULE_17
		end else if (trace_enable_flag_wr_in) begin
			next_te = trace_enable_flag_val_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			te <= 1'b0;
			saved_te <= 1'b0;
		end else begin
			te <= next_te;
			saved_te <= next_saved_te;
		end
	end

	assign te_out = te;
	assign intr_saved_te_out = saved_te;

	// ************************************************************
	// Breakpoint comparators
	// ************************************************************
	logic [`TBU_NUM_IB-1:0] ib_hit;
	logic [`TBU_NUM_DB-1:0] db_hit;
	logic dacc_chk;

	// A faulting control space access skips the breakpoint check
	assign dacc_chk = dacc_valid_in && !dacc_ctl_fault_in; // RULE_03 RULE_02

	for (genvar i = 0; i < `TBU_NUM_IB; i++) begin : g_ib
		tbu_instr_match u_im (
			.brk_reg_in(ib_reg[i]),
			.te_in(next_te),
			.valid_in(ex_valid_in),
			.ip_in(ex_ip_in),
			.hit_out(ib_hit[i])
		);
	end

	for (genvar i = 0; i < `TBU_NUM_DB; i++) begin : g_db
		tbu_data_match u_dm (
			.brk_reg_in(db_reg[i]),
			.ctl_in(break_control_reg[i*`TBU_CTL_BITS +: `TBU_CTL_BITS]),
			.te_in(next_te),
			.valid_in(dacc_chk),
			.write_in(dacc_write_in),
			.addr_in(dacc_addr_in),
			.len_in(dacc_len_in),
			.hit_out(db_hit[i])
		);
	end

	// ************************************************************
	// Event gathering and fault delivery
	// ************************************************************
	tbu_state_e state;
	tbu_state_e next_state;
	tbu_rec_t core_ev;
	tbu_rec_t next_record;
	logic [`TBU_GRP_W-1:0] grp;
	logic brk;
	logic pre;
	logic next_fault;
	logic next_ctl_fault;

	always_comb begin
		grp = ex_valid_in ? (ex_groups_in & trace_mode_in[`TBU_GRP_W-1:0]) : '0; // RULE_10
		grp[`TBU_EV_CALL] = grp[`TBU_EV_CALL] ||
			(fault_call_in && trace_mode_in[`TBU_EV_CALL]); // RULE_11
		brk = (ex_valid_in && ex_mark_in && trace_mode_in[`TBU_EV_BRK]) ||
			(ex_valid_in && ex_fmark_in) || (|ib_hit) || (|db_hit); // RULE_12 RULE_13
		// Post-instruction events see the enable left by this call or return
		core_ev = next_te ? {brk, 1'b0, grp} : '0; // RULE_20
		// Prereturn is judged before the return executes
		pre = ex_valid_in && ex_prereturn_in && trace_mode_in[`TBU_EV_PRERET] && te; // RULE_10
		next_state = state;
		next_fault = 1'b0;
		next_record = trace_record_out;
		next_ctl_fault = dacc_valid_in && dacc_ctl_fault_in; // RULE_03
		case (state)
			TBU_ST_IDLE: begin
				if (|core_ev) begin
					next_fault = 1'b1; // RULE_14
					next_record = core_ev;
					if (pre) begin
						next_state = TBU_ST_PRERET; // RULE_15
					end
				end else if (pre) begin
					next_fault = 1'b1;
					next_record = '0;
					next_record[`TBU_EV_PRERET] = 1'b1; // RULE_14
				end
			end
			TBU_ST_PRERET: begin
				if (trace_ret_in) begin
					next_fault = 1'b1; // RULE_15
					next_record = '0;
					next_record[`TBU_EV_PRERET] = 1'b1;
					next_state = TBU_ST_IDLE;
				end else if (|core_ev) begin
					next_fault = 1'b1;
					next_record = core_ev;
				end
			end
			default: next_state = TBU_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= TBU_ST_IDLE;
			trace_fault_out <= 1'b0;
			trace_record_out <= '0;
			ctl_fault_out <= 1'b0;
		end else begin
			state <= next_state;
			trace_fault_out <= next_fault;
			trace_record_out <= next_record;
			ctl_fault_out <= next_ctl_fault;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	logic calls_quiet;
	assign calls_quiet = !sup_call_trace_in && !intr_entry_in && !intr_ret_in;

	sequence s_pre_with_others;
		state == TBU_ST_IDLE && pre && (|core_ev);
	endsequence

	sequence s_others_then_hold;
		trace_fault_out && !trace_record_out[`TBU_EV_PRERET] && state == TBU_ST_PRERET;
	endsequence

	a_trace_call_clr: assert property (sup_call_trace_in |=> !te_out) // RULE_16
		else $error("trace handler call left trace enable set");
	a_sup_call_load: assert property (calls_quiet && sup_call_in |=> te_out == $past(ssp_te_in)) // RULE_17
		else $error("supervisor call did not load table trace bit");
	a_intr_entry_save: assert property (!sup_call_trace_in && intr_entry_in |=> // RULE_18
		!te_out && intr_saved_te_out == $past(te_out))
		else $error("interrupt entry did not save and clear trace enable");
	a_intr_ret_restore: assert property (!sup_call_trace_in && !intr_entry_in && intr_ret_in
		|=> te_out == $past(intr_rec_te_in)) // RULE_19
		else $error("interrupt return did not restore trace enable");
	a_no_rights_keep: assert property (reg_wr_in && acc_ok && !rights |=> // RULE_24
		unimp_fault_out && $stable(ib_reg[0]) && $stable(db_reg[0]) && $stable(break_control_reg))
		else $error("write without rights changed a register");
	a_ctl_fault_rpt: assert property (dacc_valid_in && dacc_ctl_fault_in |=> ctl_fault_out) // RULE_03
		else $error("control space fault not reported");
	a_record_shape: assert property (trace_fault_out |-> trace_record_out != '0 && // RULE_14
		(!trace_record_out[`TBU_EV_PRERET] || trace_record_out == 7'h20))
		else $error("trace record empty or prereturn not alone");
	a_preret_defer: assert property (s_pre_with_others |=> s_others_then_hold) // RULE_15
		else $error("prereturn not deferred behind other events");
	a_preret_deliver: assert property (state == TBU_ST_PRERET && trace_ret_in |=>
		trace_fault_out && trace_record_out == 7'h20 && state == TBU_ST_IDLE) // RULE_15
		else $error("deferred prereturn not delivered on handler return");
	a_ib_gate: assert property (ex_valid_in && !next_te |-> ib_hit == '0 && db_hit == '0) // RULE_05
		else $error("breakpoint hit with tracing off");

endmodule : tbu_trace_unit

// >>> shared/tbu_cfg.svh
// Constants of the trace and breakpoint unit: register indices, field
// positions, reset values and encodings.
// Assumes inclusion by bare name from the package and the bench.
`ifndef TBU_CFG_SVH
`define TBU_CFG_SVH

// ************************************************************
// Register indices
// ************************************************************
`define TBU_IDX_W 3
`define TBU_IDX_IB0 3'h0
`define TBU_IDX_IB1 3'h1
`define TBU_IDX_DB0 3'h2
`define TBU_IDX_DB1 3'h3
`define TBU_IDX_BREAK_CONTROL_REG 3'h4

// ************************************************************
// Counts, fields and encodings
// ************************************************************
`define TBU_NUM_IB 2
`define TBU_NUM_DB 2
`define TBU_CTL_BITS 4
`define TBU_CTL_E0 0
`define TBU_CTL_E1 1
`define TBU_CTL_M0 2
`define TBU_CTL_M1 3
`define TBU_MODE_ARMED 2'h3
`define TBU_DMODE_WR 2'h0
`define TBU_DMODE_RW 2'h1
`define TBU_DMODE_RD 2'h2
`define TBU_RIGHTS_VAL 8'h22
`define TBU_WORD_RST 32'h00000000
`define TBU_BREAK_CONTROL_REG_RST 8'h00

// Trace record bits and trace mode bits share positions
`define TBU_REC_W 7
`define TBU_GRP_W 5
`define TBU_EV_CALL 2
`define TBU_EV_PRERET 5
`define TBU_EV_BRK 6

`endif

// >>> shared/tbu_pkg.sv
// Types of the trace and breakpoint unit.
// Assumes tbu_cfg.svh on the include path.
`include "tbu_cfg.svh"

package tbu_pkg;

	typedef logic [31:0] tbu_word_t;
	typedef logic [`TBU_REC_W-1:0] tbu_rec_t;

	// Delivery state: idle, or a prereturn fault held back
	typedef enum logic [1:0] {
		TBU_ST_IDLE = 2'b01,
		TBU_ST_PRERET = 2'b10
	} tbu_state_e;

endpackage : tbu_pkg

// >>> hw/tbu_instr_match.sv
// One instruction address comparator.
// Assumes the fetch address and gate come from the same clock domain.
`timescale 1ns/100ps

module tbu_instr_match
	import tbu_pkg::*;
(
	input wire tbu_word_t brk_reg_in,
	input wire logic te_in,
	input wire logic valid_in,
	input wire tbu_word_t ip_in,
	output logic hit_out
);

	// Low two bits are the mode pair, not address
	always_comb begin
		hit_out = valid_in && te_in && (brk_reg_in[1:0] == `TBU_MODE_ARMED) &&
			(brk_reg_in[31:2] == ip_in[31:2]); // RULE_04 RULE_05
	end

endmodule : tbu_instr_match

// >>> hw/tbu_data_match.sv
// One data address comparator with access type qualification.
// Assumes the access length is the byte count, 1 to 16.
`timescale 1ns/100ps

module tbu_data_match
	import tbu_pkg::*;
(
	input wire tbu_word_t brk_reg_in,
	input wire logic [`TBU_CTL_BITS-1:0] ctl_in,
	input wire logic te_in,
	input wire logic valid_in,
	input wire logic write_in,
	input wire tbu_word_t addr_in,
	input wire logic [4:0] len_in,
	output logic hit_out
);

	logic [1:0] mode;
	logic [1:0] enab;
	logic type_ok;
	tbu_word_t offs;

	always_comb begin
		mode = {ctl_in[`TBU_CTL_M1], ctl_in[`TBU_CTL_M0]};
		enab = {ctl_in[`TBU_CTL_E1], ctl_in[`TBU_CTL_E0]};
		case (mode)
			`TBU_DMODE_WR: type_ok = write_in; // RULE_21 RULE_01
			`TBU_DMODE_RW: type_ok = 1'b1;
			`TBU_DMODE_RD: type_ok = !write_in;
			default: type_ok = 1'b0;
		endcase
		// Wrapping difference covers unaligned spans in one compare
		offs = brk_reg_in - addr_in; // RULE_23
		hit_out = valid_in && te_in && (enab == `TBU_MODE_ARMED) && type_ok &&
			(offs < {27'h0000000, len_in}); // RULE_22
	end

endmodule : tbu_data_match

// >>> testbench/tbu_seq_model.sv
// Model of the fault call sequencer: runs the trace handler and returns.
// Assumes the unit's trace fault pulse on core_clk_in.
`timescale 1ns/100ps

module tbu_seq_model (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic fault_in,
	input wire logic [3:0] delay_in,
	output logic trace_ret_out
);
	int cnt;

	// Handler never touches breakpoint registers, so no mixed pairs
	// are written and no plain stores race the matchers
	always @(negedge core_clk_in) begin
		if (!resetn_in) begin
			cnt <= 0;
			trace_ret_out <= 1'h0;
		end else if (cnt == 1) begin
			trace_ret_out <= 1'h1;
			cnt <= 0;
		end else begin
			trace_ret_out <= 1'h0;
			if (cnt > 1) begin
				cnt <= cnt - 1;
			end else if (fault_in) begin
				cnt <= 32'(delay_in) + 1;
			end
		end
	end
endmodule : tbu_seq_model

// >>> testbench/trace_breakpoint_unit_bench.sv
// Self-checking bench of the trace and breakpoint unit.
// Assumes tbu_pkg, the design and tbu_seq_model are compiled first.
`timescale 1ns/100ps
`include "tbu_cfg.svh"

module trace_breakpoint_unit_bench;
	import tbu_pkg::*;
	typedef struct packed {
		logic wr, rd, rq, exv, fc, mark, fmark, dv, sc, sct, ie, ir, tew;
	} tbu_pulse_s;
	tbu_pulse_s p, q;
	logic core_clk_in, resetn_in, reg_sysctl_in, reg_word_in, emu_hold_in, ex_prereturn_in;
	logic dacc_write_in, dacc_ctl_fault_in, ssp_te_in, intr_rec_te_in, trace_ret_in;
	logic trace_enable_flag_val_in, trace_fault_out, ctl_fault_out, unimp_fault_out, te_out;
	logic intr_saved_te_out, w, k;
	logic [`TBU_IDX_W-1:0] reg_idx_in;
	tbu_word_t reg_wdata_in, ex_ip_in, dacc_addr_in, reg_rdata_out, ip, d, r, base;
	logic [`TBU_GRP_W-1:0] ex_groups_in, g;
	logic [`TBU_REC_W-1:0] trace_mode_in;
	tbu_rec_t trace_record_out;
	logic [4:0] dacc_len_in, n;
	logic [3:0] ret_delay;
	logic [1:0] m;
	logic [7:0] rights_out;
	int failures, compares, seed;

	tbu_trace_unit dut_u (.core_clk_in, .resetn_in, .reg_wr_in(p.wr), .reg_rd_in(p.rd),
		.reg_sysctl_in, .reg_word_in, .reg_idx_in, .reg_wdata_in, .rights_req_in(p.rq),
		.emu_hold_in, .ex_valid_in(p.exv), .ex_ip_in, .ex_groups_in, .ex_prereturn_in,
		.ex_mark_in(p.mark), .ex_fmark_in(p.fmark), .trace_mode_in, .dacc_valid_in(p.dv),
		.dacc_addr_in, .dacc_len_in, .dacc_write_in, .dacc_ctl_fault_in,
		.fault_call_in(p.fc), .sup_call_in(p.sc), .sup_call_trace_in(p.sct), .ssp_te_in,
		.intr_entry_in(p.ie), .intr_ret_in(p.ir), .intr_rec_te_in, .trace_ret_in,
		.trace_enable_flag_wr_in(p.tew), .trace_enable_flag_val_in, .trace_fault_out, .trace_record_out,
		.ctl_fault_out, .unimp_fault_out, .te_out, .intr_saved_te_out, .reg_rdata_out,
		.rights_out);
	tbu_seq_model seq_u (.core_clk_in, .resetn_in, .fault_in(trace_fault_out),
		.delay_in(ret_delay), .trace_ret_out(trace_ret_in));

	initial core_clk_in = 1'h0;
	always #20 core_clk_in = ~core_clk_in;

	// *****************************************
	// Drivers and checks
	// *****************************************
	task automatic tick;
		@(negedge core_clk_in);
	endtask : tick

	// Pulses gathered in q go out together and stand until the next go,
	// so a pulse repeated back to back is held, never dropped and raised
	task automatic go;
		p = q;
		q = '0;
		tick();
	endtask : go

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wreg(input logic [2:0] idx, input tbu_word_t v, input logic sys, input logic wd);
		reg_idx_in = idx;
		reg_wdata_in = v;
		reg_sysctl_in = sys;
		reg_word_in = wd;
		q.wr = 1'h1;
		go();
	endtask : wreg

	task automatic rreg(input logic [2:0] idx, input logic wd, output tbu_word_t v);
		reg_idx_in = idx;
		reg_sysctl_in = ~wd;
		reg_word_in = wd;
		q.rd = 1'h1;
		go();
		v = reg_rdata_out;
	endtask : rreg

	task automatic set_te(input logic v);
		trace_enable_flag_val_in = v;
		q.tew = 1'h1;
		go();
	endtask : set_te

	task automatic exec(input tbu_word_t a, input logic [4:0] grp);
		ex_ip_in = a;
		ex_groups_in = grp;
		q.exv = 1'h1;
		go();
	endtask : exec

	task automatic dacc(input tbu_word_t a, input logic [4:0] len, input logic wr, input logic e);
		dacc_addr_in = a;
		dacc_len_in = len;
		dacc_write_in = wr;
		q.dv = 1'h1;
		go();
		chk("data break", 32'(e), 32'(trace_fault_out));
	endtask : dacc

	task automatic wait_fault(input int bound);
		for (int i = 0; i < bound; i++) begin
			if (trace_fault_out === 1'h1) return;
			tick();
		end
		failures++;
		$display("CHECK FAILED trace fault wait expected 1 seen 0");
		end_of_test();
	endtask : wait_fault

	// Write-only, read-or-write, read-only
	function automatic logic dmatch(input logic [1:0] md, input logic wr);
		return (md == 2'h1) || (wr == (md == 2'h0));
	endfunction : dmatch

	task automatic end_of_test;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test

	initial begin
		seed = 44302;
		failures = 0;
		compares = 0;
		p = '0;
		q = '0;
		{reg_sysctl_in, reg_word_in, emu_hold_in, ex_prereturn_in, dacc_write_in} = 5'h00;
		{dacc_ctl_fault_in, ssp_te_in, intr_rec_te_in, trace_enable_flag_val_in} = 4'h0;
		{reg_idx_in, reg_wdata_in, ex_ip_in, ex_groups_in, dacc_addr_in} = '0;
		{trace_mode_in, dacc_len_in, ret_delay} = '0;
		resetn_in = 1'h0;
		repeat (20) tick();
		resetn_in = 1'h1;
		tick();
		chk("te after reset", 32'h0, 32'(te_out));
		chk("rights after reset", 32'h0, 32'(rights_out));
		ip = $random(seed) & 32'hFFFF_FFFC;
		wreg(`TBU_IDX_IB0, ip | 32'h3, 1'h1, 1'h0);
		chk("unimp fault", 32'h1, 32'(unimp_fault_out));
		rreg(`TBU_IDX_IB0, 1'h0, d);
		chk("ib0 unchanged", 32'h0, d);
		emu_hold_in = 1'h1;
		q.rq = 1'h1;
		go();
		chk("rights held off", 32'h0, 32'(rights_out));
		emu_hold_in = 1'h0;
		q.rq = 1'h1;
		go();
		chk("rights", 32'h22, 32'(rights_out));
		wreg(`TBU_IDX_IB0, ip, 1'h0, 1'h1);
		rreg(`TBU_IDX_IB0, 1'h1, d);
		chk("ib0 word store", ip, d);
		wreg(`TBU_IDX_IB0, ~ip, 1'h0, 1'h0);
		rreg(`TBU_IDX_IB0, 1'h0, d);
		chk("ib0 other access", ip, d);
		rreg(3'h5, 1'h0, d);
		chk("unused index", 32'h0, d);
		set_te(1'h1);
		// Only the armed and disarmed pairs while tracing is on
		for (int i = 0; i < 2; i++) begin
			wreg(`TBU_IDX_IB0, ip | (i ? 32'h0 : 32'h3), 1'h1, 1'h0);
			exec(ip, 5'h00);
			chk("ib hit", 32'(i == 0), 32'(trace_fault_out));
			if (i == 0) begin
				chk("ib record", 32'h40, 32'(trace_record_out));
				exec(ip + 32'h4, 5'h00);
				chk("ib other word", 32'h0, 32'(trace_fault_out));
				set_te(1'h0);
				exec(ip, 5'h00);
				chk("ib te off", 32'h0, 32'(trace_fault_out));
				set_te(1'h1);
			end
		end
		wreg(`TBU_IDX_IB1, (ip + 32'h8) | 32'h3, 1'h1, 1'h0);
		exec(ip + 32'h8, 5'h00);
		chk("ib1 hit", 32'h1, 32'(trace_fault_out));
		wreg(`TBU_IDX_IB1, ip + 32'h8, 1'h1, 1'h0);
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			m = 2'(i / 2);
			w = i[0];
			k = r[4];
			base = (r & 32'h0FFF_FFF0) | 32'h0000_1000;
			n = {1'h0, r[3:0]} + 5'h1;
			wreg({2'h1, k}, base, 1'h1, 1'h0);
			wreg(`TBU_IDX_BREAK_CONTROL_REG, 32'({m, 2'h3}) << (4 * k), 1'h1, 1'h0);
			dacc(base - 32'(n) + 32'h1, n, w, dmatch(m, w));
			dacc(base + 32'h1, n, w, 1'h0);
			wreg(`TBU_IDX_BREAK_CONTROL_REG, 32'({m, 2'h0}) << (4 * k), 1'h1, 1'h0);
			dacc(base, n, w, 1'h0);
		end
		wreg(`TBU_IDX_BREAK_CONTROL_REG, 32'h7, 1'h1, 1'h0);
		wreg(`TBU_IDX_DB0, base, 1'h1, 1'h0);
		dacc_ctl_fault_in = 1'h1;
		dacc(base, 5'h4, 1'h0, 1'h0);
		chk("control space fault", 32'h1, 32'(ctl_fault_out));
		dacc_ctl_fault_in = 1'h0;
		wreg(`TBU_IDX_BREAK_CONTROL_REG, 32'h0, 1'h1, 1'h0);
		for (int i = 0; i < 8; i++) begin
			r = (i == 0) ? 32'h3FF : $random(seed);
			trace_mode_in = {2'h0, r[4:0]};
			exec(32'h0, r[9:5]);
			g = r[4:0] & r[9:5];
			chk("group fault", 32'(g != 0), 32'(trace_fault_out));
			if (g != 0) chk("group record", 32'(g), 32'(trace_record_out));
		end
		for (int i = 0; i < 5; i++) begin
			trace_mode_in = i[0] ? 7'h44 : 7'h00;
			q.fc = (i < 2);
			// Mark and forced mark are instructions, so they execute
			q.exv = (i >= 2);
			q.mark = (i == 2 || i == 3);
			q.fmark = (i == 4);
			go();
			chk("call or mark", 32'(i[0] || i == 4), 32'(trace_fault_out));
			if (i > 2) chk("mark record", 32'h1, 32'(trace_record_out[`TBU_EV_BRK]));
		end
		// Let the handler returns of the faults above drain first
		repeat (4) go();
		for (int i = 0; i < 2; i++) begin
			ret_delay = i ? 4'($random(seed)) : 4'h0;
			trace_mode_in = 7'h21;
			ex_prereturn_in = 1'h1;
			exec(32'h0, 5'h01);
			ex_prereturn_in = 1'h0;
			chk("others first", 32'h01, 32'(trace_record_out));
			go();
			wait_fault(40);
			chk("prereturn alone", 32'h20, 32'(trace_record_out));
			repeat (24) tick();
		end
		intr_rec_te_in = 1'h1;
		q.ie = 1'h1;
		go();
		chk("te in handler", 32'h0, 32'(te_out));
		chk("saved te", 32'h1, 32'(intr_saved_te_out));
		q.ir = 1'h1;
		go();
		chk("te after return", 32'h1, 32'(te_out));
		q.sct = 1'h1;
		go();
		chk("te in trace handler", 32'h0, 32'(te_out));
		ssp_te_in = 1'h1;
		trace_mode_in = 7'h01;
		q.sc = 1'h1;
		exec(32'h0, 5'h01);
		chk("te from table", 32'h1, 32'(te_out));
		chk("call traced by new te", 32'h1, 32'(trace_fault_out));
		ssp_te_in = 1'h0;
		q.sc = 1'h1;
		go();
		chk("te from table clear", 32'h0, 32'(te_out));
		// Second reset in mid run: rights, enable and registers start over
		go();
		resetn_in = 1'h0;
		repeat (2) tick();
		resetn_in = 1'h1;
		tick();
		chk("te after mid reset", 32'h0, 32'(te_out));
		chk("rights after mid reset", 32'h0, 32'(rights_out));
		rreg(`TBU_IDX_IB1, 1'h1, d);
		chk("ib1 after mid reset", 32'h0, d);
		end_of_test();
	end
endmodule : trace_breakpoint_unit_bench
